//--- core/cct_regs.vh
// register offsets, field positions and encodings of the capture timer
`ifndef CCT_REGS_VH
`define CCT_REGS_VH
// register indices (byte address is four times the index)
`define CCT_IDX_CONTROL_A   4'h0
`define CCT_IDX_CONTROL_B   4'h1
`define CCT_IDX_CONTROL_C   4'h2
`define CCT_IDX_EVENT_CONTROL  4'h4
`define CCT_IDX_INTEN   4'h5
`define CCT_IDX_FLAGS   4'h6
`define CCT_IDX_STATUS  4'h7
`define CCT_IDX_DBG     4'h8
`define CCT_IDX_BUF     4'h9
`define CCT_IDX_CNTL    4'hA
`define CCT_IDX_CNTH    4'hB
`define CCT_IDX_CCL     4'hC
`define CCT_IDX_CCH     4'hD
// control_a fields
`define CCT_A_EN        0
`define CCT_A_SYNC      4
`define CCT_A_CASC      5
`define CCT_A_STBY      6
`define CCT_A_MASK      8'h7F
// control_b fields
`define CCT_B_PINEN     4
`define CCT_B_INIT      5
`define CCT_B_EVENT_ENABLE_A     6
`define CCT_B_EVGEN     7
`define CCT_B_MASK      8'hF7
`define CCT_C_MASK      8'h07
// event_control fields
`define CCT_E_CAPTURE_INPUT_ENABLE    0
`define CCT_E_EDGE      4
`define CCT_E_FILT      6
`define CCT_E_MASK      8'h51
`define CCT_I_MASK      8'h03
`define CCT_F_CAPTURE_EVENT      0
`define CCT_F_OVF       1
// clock source select encodings
`define CCT_CLK_DIV1    3'h0
`define CCT_CLK_DIV2    3'h1
`define CCT_CLK_COMP    3'h2
`define CCT_CLK_EVENT   3'h7
// timer modes
`define CCT_M_INT       3'h0
`define CCT_M_TIMEOUT   3'h1
`define CCT_M_CAPTURE_EVENT      3'h2
`define CCT_M_FRQ       3'h3
`define CCT_M_PW        3'h4
`define CCT_M_FRQPW     3'h5
`define CCT_M_SINGLE    3'h6
`define CCT_M_PWM8      3'h7
`define CCT_MAX         16'hFFFF
`define CCT_BOTTOM      16'h0000
`endif

//--- core/cct_timer.v
// cascadable 16-bit capture timer with wishbone register slave
// Notes on behaviour
// - upper register is high half, lower low
// - chain setting aligns shared capture timing
// - chain enable delays capture by one cycle
// - filter passes input after four equal samples
// - filter adds four cycles of latency
// - filter samples undivided peripheral clock
// - companion clock select counts companion ticks
// - restart sync follows companion counter restart
// - pin enable overrides port output value
// - event pulses mirror flag set conditions
// - event clock select counts input events
// - clock select encodings 0,1,2,7; rest reserved
// - capture enable acts per edge and mode
// - event_enable_a single shot catches short pulses
// - overflow on wrap from max to bottom
// - flags set regardless of interrupt enable
// - request while flag and enable set
// - halt on standby entry by default
// - standby run keeps unit operating
// - power down halts all but the register slave, pin logic and the event_enable_a pulse latch
`include "cct_regs.vh"
`default_nettype none
module cct_timer (
    input  wire        mclk_i,
    input  wire        nrst_i,
    input  wire        ce_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [5:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output wire        wb_ack_o,
    input  wire        capture_event_ev_i,
    input  wire        count_ev_i,
    input  wire        comp_tick_i,
    input  wire        comp_restart_i,
    input  wire        standby_i,
    input  wire        powerdown_i,
    input  wire        debug_halt_i,
    input  wire        port_out_i,
    output reg         pin_o,
    output reg         pin_oe_o,
    output reg         capture_event_ev_o,
    output reg         ovf_ev_o,
    output wire        irq_o
);
    reg  [7:0]  control_a;
    reg  [7:0]  control_b;
    reg  [7:0]  control_c;
    reg  [7:0]  event_control;
    reg  [7:0]  inten;
    reg  [1:0]  flags;
    reg         debug_run_enable;
    reg  [7:0]  buf_q;
    reg  [15:0] cnt;
    reg  [15:0] compare_capture_value;
    reg         run;
    reg         wave;
    reg         ack_q;
    reg         div_q;
    reg         cnt_ev_q;
    reg  [2:0]  filt;
    reg         filt_out;
    reg         cap_q;
    reg         cap_dly;
    reg         event_enable_a_hit;
    reg         event_enable_a_ack;
    reg         next_run;
    reg         next_wave;
    reg  [15:0] next_cnt;
    reg  [15:0] next_compare_capture_value;
    reg         set_capture_event;
    reg         set_ovf;
    reg  [31:0] next_rdata;
    wire [2:0]  clock_source_select = control_a[3:1];
    wire [2:0]  mode   = control_b[2:0];
    wire [3:0]  idx    = wb_adr_i[5:2];
    wire        wr     = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ~ack_q;
    wire        rdacc  = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q;
    wire        w_byte = wr;
    wire [7:0]  wd     = wb_dat_i[7:0];
    wire        wr_flags = w_byte & (idx == `CCT_IDX_FLAGS);
    wire        wr_cnth  = w_byte & (idx == `CCT_IDX_CNTH);
    wire        wr_cch   = w_byte & (idx == `CCT_IDX_CCH);
    // ****************************************************************
    // power gating
    // ****************************************************************
    wire        asleep = powerdown_i
                       | (standby_i & ~control_a[`CCT_A_STBY])
                       | (debug_halt_i & ~debug_run_enable);
    // standby with run bit set keeps the unit alive
    wire        go     = ce_i & ~asleep;
    wire        en     = control_a[`CCT_A_EN];
    // ****************************************************************
    // input filter and edge detection
    // ****************************************************************
    wire [3:0]  window = {filt, capture_event_ev_i};
    wire        stable = (window == 4'hF) | (window == 4'h0);
    wire        cap_in = event_control[`CCT_E_FILT] ? filt_out : capture_event_ev_i;
    wire        cap_rise = cap_in & ~cap_q;
    wire        cap_fall = ~cap_in & cap_q;
    wire        cap_edge_raw = event_control[`CCT_E_EDGE] ? cap_fall : cap_rise;
    wire        cap_any = control_a[`CCT_A_CASC] ? cap_dly : cap_edge_raw;
    wire        cap_hit = event_control[`CCT_E_CAPTURE_INPUT_ENABLE] & cap_any;
    wire        event_enable_a_seen;
    cct_sync2 u_event_enable_a_sync (
        .clk_i  (mclk_i),
        .nrst_i (nrst_i),
        .en_i   (go),
        .d_i    (event_enable_a_hit),
        .q_o    (event_enable_a_seen)
    );
    wire        event_enable_a_pulse = event_enable_a_seen ^ event_enable_a_ack;
    // ****************************************************************
    // count tick selection
    // ****************************************************************
    reg         tick;
    always @* begin
        case (clock_source_select)
            `CCT_CLK_DIV1:  tick = 1'b1;
            `CCT_CLK_DIV2:  tick = div_q;
            `CCT_CLK_COMP:  tick = comp_tick_i;
            `CCT_CLK_EVENT: tick = count_ev_i & ~cnt_ev_q;
            default:        tick = 1'b0;
        endcase
    end
    wire        restart = control_a[`CCT_A_SYNC] & comp_restart_i;
    // ****************************************************************
    // counter and capture state machine
    // ****************************************************************
    always @* begin
        next_cnt  = cnt;
        next_compare_capture_value = compare_capture_value;
        next_run  = run;
        next_wave = wave;
        set_capture_event  = 1'b0;
        set_ovf   = 1'b0;
        if (en) begin
            if (restart) begin
                next_cnt = `CCT_BOTTOM;
            end else if (tick & run) begin
                next_cnt = cnt + 16'h0001;
                if (cnt == `CCT_MAX) begin
                    set_ovf = 1'b1;
                end
            end
            case (mode)
                `CCT_M_INT: begin
                    next_run = 1'b1;
                    if (tick && cnt == compare_capture_value) begin
                        next_cnt = `CCT_BOTTOM;
                        set_capture_event = 1'b1;
                    end
                end
                `CCT_M_TIMEOUT: begin
                    next_run = 1'b1;
                    if (cap_hit) begin
                        next_cnt = `CCT_BOTTOM;
                    end else if (tick && cnt == compare_capture_value) begin
                        set_capture_event = 1'b1;
                    end
                end
                `CCT_M_CAPTURE_EVENT: begin
                    // the whole 16-bit count latches into compare_capture_value on one event
                    next_run = 1'b1;
                    if (cap_hit) begin
                        next_compare_capture_value = cnt;
                        set_capture_event  = 1'b1;
                    end
                end
                `CCT_M_FRQ, `CCT_M_PW, `CCT_M_FRQPW: begin
                    next_run = 1'b1;
                    if (cap_hit) begin
                        next_compare_capture_value = cnt;
                        next_cnt  = `CCT_BOTTOM;
                        set_capture_event  = 1'b1;
                    end
                end
                `CCT_M_SINGLE: begin
                    if (!run && (cap_hit || (control_b[`CCT_B_EVENT_ENABLE_A]
                        && event_enable_a_pulse))) begin
                        next_run  = 1'b1;
                        next_cnt  = `CCT_BOTTOM;
                        next_wave = 1'b1;
                    end else if (run && tick && cnt == compare_capture_value) begin
                        next_run  = 1'b0;
                        next_wave = 1'b0;
                        set_capture_event  = 1'b1;
                    end
                end
                `CCT_M_PWM8: begin
                    next_run = 1'b1;
                    if (tick) begin
                        if (cnt[7:0] == compare_capture_value[7:0]) begin
                            next_cnt  = `CCT_BOTTOM;
                            next_wave = 1'b1;
                            set_ovf   = 1'b1;
                        end else if (cnt[7:0] == compare_capture_value[15:8]) begin
                            next_wave = 1'b0;
                        end
                    end
                end
                default: next_run = run;
            endcase
        end else begin
            next_run  = 1'b0;
            next_wave = control_b[`CCT_B_INIT];
        end
    end
    // ****************************************************************
    // clocked state
    // ****************************************************************
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt       <= 16'h0000;
            compare_capture_value      <= 16'h0000;
            run       <= 1'b0;
            wave      <= 1'b0;
            div_q     <= 1'b0;
            cnt_ev_q  <= 1'b0;
            filt      <= 3'h0;
            filt_out  <= 1'b0;
            cap_q     <= 1'b0;
            cap_dly   <= 1'b0;
            flags     <= 2'h0;
            capture_event_ev_o <= 1'b0;
            ovf_ev_o  <= 1'b0;
            event_enable_a_ack <= 1'b0;
        end else if (go) begin
            div_q    <= ~div_q;
            cnt_ev_q <= count_ev_i;
            filt     <= {filt[1:0], capture_event_ev_i};
            if (stable) begin
                filt_out <= capture_event_ev_i;
            end
            cap_q    <= cap_in;
            cap_dly  <= cap_edge_raw;
            event_enable_a_ack <= event_enable_a_seen;
            capture_event_ev_o <= set_capture_event;
            ovf_ev_o  <= set_ovf;
            cnt  <= next_cnt;
            compare_capture_value <= next_compare_capture_value;
            run  <= next_run;
            wave <= next_wave;
            // set wins over a write-one clear
            flags <= (flags & ~(wr_flags ? wd[1:0] : 2'h0))
                     | {set_ovf, set_capture_event};
            if (wr_cnth) begin
                cnt <= {wd, buf_q};
            end
            if (wr_cch) begin
                compare_capture_value <= {wd, buf_q};
            end
        end else begin
            capture_event_ev_o <= 1'b0;
            ovf_ev_o  <= 1'b0;
        end
    end
    // short event_enable_a pulses latched in single shot mode
    always @(posedge capture_event_ev_i or negedge nrst_i) begin
        if (!nrst_i) begin
            event_enable_a_hit <= 1'b0;
        end else begin
            event_enable_a_hit <= ~event_enable_a_hit;
        end
    end
    // ****************************************************************
    // read data select
    // ****************************************************************
    always @* begin
        next_rdata = 32'h00000000;
        case (idx)
            `CCT_IDX_CONTROL_A:  next_rdata[7:0] = control_a;
            `CCT_IDX_CONTROL_B:  next_rdata[7:0] = control_b;
            `CCT_IDX_CONTROL_C:  next_rdata[7:0] = control_c;
            `CCT_IDX_EVENT_CONTROL: next_rdata[7:0] = event_control;
            `CCT_IDX_INTEN:  next_rdata[7:0] = inten;
            `CCT_IDX_FLAGS:  next_rdata[1:0] = flags;
            `CCT_IDX_STATUS: next_rdata[0]   = run;
            `CCT_IDX_DBG:    next_rdata[0]   = debug_run_enable;
            `CCT_IDX_BUF:    next_rdata[7:0] = buf_q;
            `CCT_IDX_CNTL:   next_rdata[7:0] = cnt[7:0];
            `CCT_IDX_CNTH:   next_rdata[7:0] = buf_q;
            `CCT_IDX_CCL:    next_rdata[7:0] = compare_capture_value[7:0];
            `CCT_IDX_CCH:    next_rdata[7:0] = buf_q;
            default:         next_rdata = 32'h00000000;
        endcase
    end
    // ****************************************************************
    // register slave
    // ****************************************************************
    assign wb_ack_o = ack_q;
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_q  <= 1'b0;
            control_a  <= 8'h00;
            control_b  <= 8'h00;
            control_c  <= 8'h00;
            event_control <= 8'h00;
            inten  <= 8'h00;
            debug_run_enable <= 1'b0;
            buf_q  <= 8'h00;
            wb_dat_o <= 32'h00000000;
        end else begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
            if (w_byte) begin
                case (idx)
                    `CCT_IDX_CONTROL_A:  control_a  <= wd & `CCT_A_MASK;
                    `CCT_IDX_CONTROL_B:  control_b  <= wd & `CCT_B_MASK;
                    `CCT_IDX_CONTROL_C:  control_c  <= wd & `CCT_C_MASK;
                    `CCT_IDX_EVENT_CONTROL: event_control <= wd & `CCT_E_MASK;
                    `CCT_IDX_INTEN:  inten  <= wd & `CCT_I_MASK;
                    `CCT_IDX_DBG:    debug_run_enable <= wd[0];
                    `CCT_IDX_BUF:    buf_q  <= wd;
                    `CCT_IDX_CNTL:   buf_q  <= wd;
                    `CCT_IDX_CCL:    buf_q  <= wd;
                    default:         buf_q  <= buf_q;
                endcase
            end else if (rdacc) begin
                case (idx)
                    `CCT_IDX_CNTL: buf_q <= cnt[15:8];
                    `CCT_IDX_CCL:  buf_q <= compare_capture_value[15:8];
                    default:       buf_q <= buf_q;
                endcase
            end
            if (rdacc) begin
                wb_dat_o <= next_rdata;
            end
        end
    end
    // ****************************************************************
    // pin and interrupt
    // ****************************************************************
    assign irq_o = |(flags & inten[1:0]);
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_o    <= 1'b0;
            pin_oe_o <= 1'b0;
        end else begin
            pin_oe_o <= control_b[`CCT_B_PINEN];
            pin_o    <= control_b[`CCT_B_PINEN] ? wave : port_out_i;
        end
    end
endmodule // cct_timer
// ****************************************************************
// two-stage synchroniser
// ****************************************************************
module cct_sync2 (
    input  wire        clk_i,
    input  wire        nrst_i,
    input  wire        en_i,
    input  wire        d_i,
    output wire        q_o
);
    reg         s1;
    reg         s2;
    assign q_o = s2;
    // only the second stage is read outside
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
        end else if (en_i) begin
            s1 <= d_i;
            s2 <= s1;
        end
    end
endmodule // cct_sync2
`default_nettype wire

//--- test/cct_timer_props.sv
// port assertions of the capture timer
`default_nettype none
module cct_timer_props (
    input wire logic        mclk_i,
    input wire logic        nrst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        powerdown_i,
    input wire logic        pin_oe_o,
    input wire logic        capture_event_ev_o,
    input wire logic        ovf_ev_o,
    input wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // properties
    // ********
    default clocking dc @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);
    ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after a request");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read data not zero");
    capture_event_pulse_a: assert property (capture_event_ev_o |=> !capture_event_ev_o)
        else $error("capture event longer than one cycle");
    ovf_pulse_a: assert property (ovf_ev_o |=> !ovf_ev_o)
        else $error("overflow event longer than one cycle");
    pd_quiet_a: assert property (
        powerdown_i && $past(powerdown_i) |-> !(capture_event_ev_o || ovf_ev_o))
        else $error("event pulse in power down");
    irq_hold_a: assert property (
        $fell(irq_o) |-> wb_ack_o && wb_we_i)
        else $error("request dropped without a write");
    irq_rise_a: assert property (
        $rose(irq_o) |-> capture_event_ev_o || ovf_ev_o || wb_ack_o
            || $past(capture_event_ev_o) || $past(ovf_ev_o))
        else $error("request raised without cause");
    pin_oe_a: assert property (
        $changed(pin_oe_o) |-> wb_ack_o || $past(wb_ack_o))
        else $error("pin enable moved without a write");
endmodule // cct_timer_props
bind cct_timer cct_timer_props u_props (.mclk_i, .nrst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .powerdown_i, .pin_oe_o,
    .capture_event_ev_o, .ovf_ev_o, .irq_o);
`default_nettype wire

//--- test/cct_far_end.sv
// far side model: event network and companion timer
`default_nettype none
module cct_far_end (
    input  wire logic mclk_i,
    input  wire logic nrst_i,
    input  wire logic capture_event_req_i,
    input  wire logic go_i,
    input  wire logic restart_req_i,
    output var  logic capture_event_ev_o,
    output var  logic count_ev_o,
    output var  logic comp_tick_o,
    output var  logic comp_restart_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {phase, capture_event_ev_o, count_ev_o, comp_tick_o, comp_restart_o} <= '0;
        end else begin
            phase          <= go_i ? phase + 2'h1 : phase;
            // one route feeds every capture input
            capture_event_ev_o      <= capture_event_req_i;
            comp_tick_o    <= go_i && phase[0];
            count_ev_o     <= go_i && phase[1];
            comp_restart_o <= restart_req_i && !go_i;
        end
    end
endmodule // cct_far_end
`default_nettype wire

//--- test/cct_timer_bench.sv
// self-checking bench of the capture timer
`include "cct_regs.vh"
`default_nettype none
`define CHK(a, e) begin \
    tests_run++; \
    if ((a) !== (e)) begin \
        num_errors++; \
        $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); \
    end \
end
module cct_timer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, nrst, ce, cyc, we, ack, pin, oe, cev, oev, irq;
    logic        creq, go, rreq, stby, pd, dbg, pout, cin, nin, tin, rin;
    logic [5:0]  adr;
    logic [31:0] wd, rdat;
    logic [7:0]  q, a, d;
    int          num_errors, tests_run, ncap, novf, lo, hi, x;
    logic [7:0]  rm [9] = '{`CCT_A_MASK, `CCT_B_MASK, `CCT_C_MASK, 8'h00,
                           `CCT_E_MASK, `CCT_I_MASK, 8'h00, 8'h00, 8'h01};
    logic [2:0]  cs [4] = '{`CCT_CLK_DIV1, `CCT_CLK_DIV2, `CCT_CLK_COMP,
                           `CCT_CLK_EVENT};
    int          dl [4] = '{43, 21, 21, 10};
    int          dh [4] = '{43, 22, 22, 11};
    logic [2:0]  sl [4] = '{3'h4, 3'h4, 3'h2, 3'h1};
    logic [7:0]  ca [4] = '{8'h01, 8'h41, 8'h41, 8'h41};
    logic        fz [4] = '{1'h1, 1'h0, 1'h1, 1'h1};
    cct_timer u_dut (
        .mclk_i(clk), .nrst_i(nrst), .ce_i(ce), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .capture_event_ev_i(cin),
        .count_ev_i(nin), .comp_tick_i(tin), .comp_restart_i(rin),
        .standby_i(stby), .powerdown_i(pd), .debug_halt_i(dbg),
        .port_out_i(pout), .pin_o(pin), .pin_oe_o(oe), .capture_event_ev_o(cev),
        .ovf_ev_o(oev), .irq_o(irq));
    cct_far_end u_far (
        .mclk_i(clk), .nrst_i(nrst), .capture_event_req_i(creq), .go_i(go),
        .restart_req_i(rreq), .capture_event_ev_o(cin), .count_ev_o(nin),
        .comp_tick_o(tin), .comp_restart_o(rin));
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (cev) ncap++;
        if (oev) novf++;
    end
    // ********
    // tasks
    // ********
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] i,
                       input logic [7:0] v);
        int k;
        @(posedge clk);
        cyc <= 1'h1;
        we  <= w;
        adr <= {i, 2'h0};
        wd  <= {24'h000000, v};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'h1 && k < 20);
        q = rdat[7:0];
        cyc <= 1'h0;
        if (k >= 20) begin
            num_errors++;
            print_verdict();
        end
    endtask
    // cycles from capture request to event pulse
    task automatic lat(output int m);
        @(posedge clk);
        creq <= 1'h1;
        m = 0;
        do begin
            @(posedge clk);
            m++;
        end while (cev !== 1'h1 && m < 40);
        repeat (8) @(posedge clk);
        creq <= 1'h0;
        repeat (12) @(posedge clk);
        if (m >= 40) begin
            num_errors++;
            print_verdict();
        end
    endtask
    task automatic pls(input int len, input int exp);
        x = ncap;
        @(posedge clk);
        creq <= 1'h1;
        repeat (len) @(posedge clk);
        creq <= 1'h0;
        repeat (20) @(posedge clk);
        `CHK(ncap - x, exp)
    endtask
    task automatic far_restart;
        @(posedge clk);
        rreq <= 1'h1;
        @(posedge clk);
        rreq <= 1'h0;
        repeat (4) @(posedge clk);
    endtask
    // ********
    // sequence
    // ********
    initial begin
        {nrst, cyc, we, creq, go, rreq, stby, pd, dbg, pout} = '0;
        ce = 1'h1;
        adr = 6'h00;
        wd = 32'h00000000;
        repeat (12) @(posedge clk);
        nrst <= 1'h1;
        for (int j = 0; j < 9; j++) begin
            bus(1'h0, j[3:0], 8'h00);
            `CHK(q, 8'h00)
            bus(1'h1, j[3:0], 8'hFF);
            bus(1'h0, j[3:0], 8'h00);
            `CHK(q, rm[j])
            bus(1'h1, j[3:0], 8'h00);
        end
        $display("test registers done");
        bus(1'h1, `CCT_IDX_CNTL, 8'hF0);
        bus(1'h1, `CCT_IDX_CNTH, 8'hA5);
        bus(1'h0, `CCT_IDX_CNTL, 8'h00);
        `CHK(q, 8'hF0)
        bus(1'h0, `CCT_IDX_BUF, 8'h00);
        `CHK(q, 8'hA5)
        bus(1'h0, `CCT_IDX_CNTH, 8'h00);
        `CHK(q, 8'hA5)
        $display("test wide access done");
        bus(1'h1, `CCT_IDX_CONTROL_B, {5'h00, `CCT_M_CAPTURE_EVENT});
        bus(1'h1, `CCT_IDX_CONTROL_A, 8'h01);
        bus(1'h1, `CCT_IDX_EVENT_CONTROL, 8'h01);
        lat(lo);
        bus(1'h1, `CCT_IDX_EVENT_CONTROL, 8'h41);
        lat(hi);
        `CHK(hi - lo, 4)
        bus(1'h1, `CCT_IDX_CONTROL_A, 8'h03);
        lat(hi);
        `CHK(hi - lo, 4)
        bus(1'h1, `CCT_IDX_CONTROL_A, 8'h01);
        pls(3, 0);
        bus(1'h1, `CCT_IDX_EVENT_CONTROL, 8'h01);
        bus(1'h1, `CCT_IDX_CONTROL_A, 8'h21);
        lat(hi);
        `CHK(hi - lo, 1)
        bus(1'h1, `CCT_IDX_CONTROL_A, 8'h01);
        bus(1'h1, `CCT_IDX_EVENT_CONTROL, 8'h00);
        pls(8, 0);
        $display("test capture timing done");
        bus(1'h1, `CCT_IDX_EVENT_CONTROL, 8'h01);
        bus(1'h1, `CCT_IDX_FLAGS, 8'h03);
        pls(8, 1);
        bus(1'h0, `CCT_IDX_FLAGS, 8'h00);
        `CHK(q, 8'h01)
        `CHK(irq, 1'h0)
        bus(1'h1, `CCT_IDX_INTEN, 8'h01);
        `CHK(irq, 1'h1)
        bus(1'h1, `CCT_IDX_FLAGS, 8'h00);
        `CHK(irq, 1'h1)
        bus(1'h1, `CCT_IDX_FLAGS, 8'h01);
        `CHK(irq, 1'h0)
        bus(1'h1, `CCT_IDX_EVENT_CONTROL, 8'h00);
        bus(1'h1, `CCT_IDX_INTEN, 8'h02);
        x = novf;
        bus(1'h1, `CCT_IDX_CNTL, 8'hF0);
        bus(1'h1, `CCT_IDX_CNTH, 8'hFF);
        repeat (40) @(posedge clk);
        `CHK(novf - x, 1)
        bus(1'h0, `CCT_IDX_FLAGS, 8'h00);
        `CHK(q, 8'h02)
        `CHK(irq, 1'h1)
        bus(1'h1, `CCT_IDX_FLAGS, 8'h02);
        $display("test flags done");
        go <= 1'h1;
        for (int j = 0; j < 4; j++) begin
            bus(1'h1, `CCT_IDX_CONTROL_A, {4'h0, cs[j], 1'h1});
            bus(1'h0, `CCT_IDX_CNTL, 8'h00);
            a = q;
            repeat (40) @(posedge clk);
            bus(1'h0, `CCT_IDX_CNTL, 8'h00);
            d = q - a;
            `CHK(d inside {[dl[j]:dh[j]]}, 1'h1)
        end
        go <= 1'h0;
        bus(1'h1, `CCT_IDX_CONTROL_A, 8'h05);
        bus(1'h1, `CCT_IDX_CNTL, 8'h55);
        bus(1'h1, `CCT_IDX_CNTH, 8'h00);
        far_restart();
        bus(1'h0, `CCT_IDX_CNTL, 8'h00);
        `CHK(q, 8'h55)
        bus(1'h1, `CCT_IDX_CONTROL_A, 8'h15);
        far_restart();
        bus(1'h0, `CCT_IDX_CNTL, 8'h00);
        `CHK(q, 8'h00)
        $display("test clock sources done");
        for (int j = 0; j < 4; j++) begin
            bus(1'h1, `CCT_IDX_CONTROL_A, ca[j]);
            {stby, pd, dbg} <= sl[j];
            bus(1'h0, `CCT_IDX_CNTL, 8'h00);
            a = q;
            repeat (20) @(posedge clk);
            bus(1'h0, `CCT_IDX_CNTL, 8'h00);
            `CHK(q == a, fz[j])
            {stby, pd, dbg} <= 3'h0;
        end
        $display("test sleep done");
        bus(1'h1, `CCT_IDX_CONTROL_A, 8'h00);
        bus(1'h1, `CCT_IDX_CONTROL_B, 8'h30);
        repeat (2) @(posedge clk);
        `CHK(oe, 1'h1)
        `CHK(pin, 1'h1)
        bus(1'h1, `CCT_IDX_CONTROL_B, 8'h20);
        repeat (2) @(posedge clk);
        `CHK(oe, 1'h0)
        $display("test pin done");
        print_verdict();
    end
endmodule // cct_timer_bench
`default_nettype wire
